// ---- hw/flash_read_pkg.sv ----
/*
  Constants for the serial flash read, transfer and compare front end.
  Assumes a single 40 MHz system clock; serial pins arrive asynchronously.
*/
`default_nettype none

package flash_read_pkg;

  localparam int PAGE_COUNT = 4096;
  localparam int PAGE_BYTES = 264;
  localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
  localparam int MEM_AW = 21;
  localparam int PAGE_W = 12;
  localparam int OFS_W = 9;

  localparam logic [7:0] OP_PAGE_READ = 8'h52;
  localparam logic [7:0] OP_BUF1_READ = 8'h54;
  localparam logic [7:0] OP_BUF2_READ = 8'h56;
  localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
  localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
  localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
  localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
  localparam logic [7:0] OP_STATUS = 8'h57;

  // bit counts seen on the serial input, opcode included
  localparam logic [6:0] CNT_OPCODE = 7'h08;
  localparam logic [6:0] CNT_ADDR = 7'h20;
  localparam logic [6:0] CNT_BUF_DATA = 7'h28;
  localparam logic [6:0] CNT_PAGE_DATA = 7'h40;
  localparam logic [6:0] CNT_MAX = 7'h7F;

  // page field within the 24 address bits
  localparam int PAGE_LSB = 9;
  localparam int PAGE_MSB = 20;

  localparam int STAT_READY = 7;
  localparam int STAT_CMP = 6;
  // density code value is arbitrary
  localparam logic [2:0] DENSITY_CODE = 3'h0;

  // one byte moved or compared per system clock
  localparam logic [8:0] LAST_BYTE = 9'(PAGE_BYTES - 1);

  typedef enum logic [2:0] {
    M_CMD,
    M_PAGE_RD,
    M_BUF_RD,
    M_STATUS,
    M_ARRAY_OP,
    M_IGNORE
  } mode_t;

endpackage

`default_nettype wire

// ---- hw/flash_read_core.sv ----
/*
  Serial command front end of a page-organised flash: page read, buffer
  read, status read, page-to-buffer transfer and compare.
  Assumes cs_n, sck and si come from another clock domain and that sck is
  well below half the 40 MHz system clock. The array is preloaded through
  the load port on the system clock.
*/
`default_nettype none

module flash_read_core
  import flash_read_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  output logic ready,
  input wire logic load_en,
  input wire logic [flash_read_pkg::MEM_AW-1:0] load_addr,
  input wire logic [7:0] load_data
);

  import flash_read_pkg::*;

  // ****************************************
  // state and storage
  // ****************************************
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] si_sync;
    logic cs_q;
    logic sck_q;
    logic [31:0] shift_in;
    logic [6:0] cnt;
    logic [7:0] opcode;
    mode_t mode;
    logic buf_sel;
    logic [PAGE_W-1:0] page_number;
    logic [OFS_W-1:0] ptr;
    logic [7:0] out_byte;
    logic [2:0] out_bit;
    logic so;
    logic oe;
    logic busy;
    logic op_cmp;
    logic op_buf;
    logic [PAGE_W-1:0] op_page;
    logic [8:0] idx;
    logic diff;
    logic cmp_res;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [7:0] main_mem [MEM_BYTES];
  logic [7:0] buf_mem [2][PAGE_BYTES];

  function automatic logic [MEM_AW-1:0] mem_index(input logic [PAGE_W-1:0] pg,
                                                  input logic [8:0] ofs);
    mem_index = MEM_AW'(pg * PAGE_BYTES) + MEM_AW'(ofs);
  endfunction

  function automatic logic [OFS_W-1:0] next_ofs(input logic [OFS_W-1:0] ofs);
    next_ofs = (ofs >= LAST_BYTE) ? '0 : ofs + 1'b1;
  endfunction

  // ****************************************
  // serial edges and fetch
  // ****************************************
  logic cs_hi;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic [31:0] shifted;
  logic [6:0] cnt_inc;
  logic [7:0] status_byte;
  logic [7:0] fetch;
  logic [7:0] op_main;
  logic [7:0] op_bufb;
  logic data_phase;

  assign cs_hi = state_reg.cs_sync[1];
  assign sck_rise = state_reg.sck_sync[1] & ~state_reg.sck_q;
  assign sck_fall = ~state_reg.sck_sync[1] & state_reg.sck_q;
  assign cs_rise = cs_hi & ~state_reg.cs_q;
  assign shifted = {state_reg.shift_in[30:0], state_reg.si_sync[1]};
  assign cnt_inc = (state_reg.cnt == CNT_MAX) ? CNT_MAX : state_reg.cnt + 1'b1;
  assign status_byte = {~state_reg.busy, state_reg.cmp_res, DENSITY_CODE, 3'h0};
  assign op_main = main_mem[mem_index(state_reg.op_page, state_reg.idx)];
  assign op_bufb = buf_mem[state_reg.op_buf][state_reg.idx];

  always_comb
  begin
    case (state_reg.mode)
      M_PAGE_RD: fetch = main_mem[mem_index(state_reg.page_number, state_reg.ptr)];
      M_BUF_RD: fetch = buf_mem[state_reg.buf_sel][state_reg.ptr];
      M_STATUS: fetch = status_byte;
      default: fetch = 8'h00;
    endcase
  end

  always_comb
  begin
    case (state_reg.mode)
      M_PAGE_RD: data_phase = state_reg.cnt >= CNT_PAGE_DATA;
      M_BUF_RD: data_phase = state_reg.cnt >= CNT_BUF_DATA;
      M_STATUS: data_phase = state_reg.cnt >= CNT_OPCODE;
      default: data_phase = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.cs_sync = {state_reg.cs_sync[0], cs_n};
    state_next.sck_sync = {state_reg.sck_sync[0], sck};
    state_next.si_sync = {state_reg.si_sync[0], si};
    state_next.cs_q = state_reg.cs_sync[1];
    state_next.sck_q = state_reg.sck_sync[1];

    if (cs_hi)
    begin
      // deselected: drop the frame and release the output
      state_next.cnt = '0;
      state_next.mode = M_CMD;
      state_next.out_bit = '0;
      state_next.oe = 1'b0;
      state_next.so = 1'b0;
      // complete command only: count reached the full address
      if (cs_rise && state_reg.mode == M_ARRAY_OP && state_reg.cnt >= CNT_ADDR)
      begin
        state_next.busy = 1'b1;
        state_next.op_cmp = state_reg.opcode[5];
        state_next.op_buf = state_reg.buf_sel;
        state_next.op_page = state_reg.page_number;
        state_next.idx = '0;
        state_next.diff = 1'b0;
      end
    end
    else
    begin
      if (sck_rise)
      begin
        state_next.shift_in = shifted;
        state_next.cnt = cnt_inc;
        if (cnt_inc == CNT_OPCODE)
        begin
          state_next.opcode = shifted[7:0];
          state_next.buf_sel = 1'b0;
          case (shifted[7:0])
            OP_STATUS: state_next.mode = M_STATUS;
            OP_PAGE_READ: state_next.mode = state_reg.busy ? M_IGNORE : M_PAGE_RD;
            OP_BUF1_READ: state_next.mode = state_reg.busy ? M_IGNORE : M_BUF_RD;
            OP_XFER_BUF1, OP_CMP_BUF1: state_next.mode = state_reg.busy ? M_IGNORE : M_ARRAY_OP;
            OP_BUF2_READ:
            begin
              state_next.mode = state_reg.busy ? M_IGNORE : M_BUF_RD;
              state_next.buf_sel = 1'b1;
            end
            OP_XFER_BUF2, OP_CMP_BUF2:
            begin
              state_next.mode = state_reg.busy ? M_IGNORE : M_ARRAY_OP;
              state_next.buf_sel = 1'b1;
            end
            default: state_next.mode = M_IGNORE;
          endcase
        end
        if (cnt_inc == CNT_ADDR)
        begin
          state_next.page_number = shifted[PAGE_MSB:PAGE_LSB];
          state_next.ptr = (shifted[OFS_W-1:0] > LAST_BYTE) ? '0 : shifted[OFS_W-1:0];
        end
      end
      if (sck_fall && data_phase)
      begin
        state_next.oe = 1'b1;
        if (state_reg.out_bit == 3'h0)
        begin
          state_next.so = fetch[7];
          state_next.out_byte = {fetch[6:0], 1'b0};
          state_next.out_bit = 3'h7;
          state_next.ptr = next_ofs(state_reg.ptr);
        end
        else
        begin
          state_next.so = state_reg.out_byte[7];
          state_next.out_byte = {state_reg.out_byte[6:0], 1'b0};
          state_next.out_bit = state_reg.out_bit - 1'b1;
        end
      end
    end

    // self-timed array operation, one byte per clock
    if (state_reg.busy)
    begin
      if (op_main != op_bufb)
        state_next.diff = 1'b1;
      if (state_reg.idx == LAST_BYTE)
      begin
        state_next.busy = 1'b0;
        if (state_reg.op_cmp)
          state_next.cmp_res = state_reg.diff | (op_main != op_bufb);
      end
      else
        state_next.idx = state_reg.idx + 1'b1;
    end

    if (rst)
    begin
      state_next = '0;
      state_next.cs_sync = 2'h3;
      state_next.cs_q = 1'b1;
      state_next.mode = M_CMD;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  // ****************************************
  // storage writes
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (load_en)
      main_mem[load_addr] <= load_data;
  end

  always_ff @(posedge clk)
  begin
    if (state_reg.busy && !state_reg.op_cmp)
      buf_mem[state_reg.op_buf][state_reg.idx] <= op_main;
  end

  assign so_out = state_reg.so;
  assign so_oe = state_reg.oe;
  assign ready = ~state_reg.busy;

endmodule

`default_nettype wire

// ---- test/flash_read_sva.sv ----
/* Checker on the ports of flash_read_core.
   Assumes sck is much slower than clk. */
`default_nettype none
module flash_read_sva
  import flash_read_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic ready,
  input wire logic load_en,
  input wire logic [flash_read_pkg::MEM_AW-1:0] load_addr,
  input wire logic [7:0] load_data
);
  // ********
  // checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("output still driven after deselect");
  chk_idle_quiet: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
  chk_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output enabled outside a frame");
  chk_oe_after_fall: assert property ($rose(so_oe) |-> $past(sck, 5))
    else $error("output enabled without a clock fall");
  chk_data_steady: assert property (so_oe && sck && $past(sck) |-> $stable(so_out))
    else $error("output data moved while clock high");
  chk_busy_on_cs: assert property ($fell(ready) |-> cs_n && $past(cs_n, 2))
    else $error("busy began inside a frame");
  chk_busy_min: assert property ($fell(ready) |-> !ready [*8])
    else $error("busy too short");
  chk_busy_bound: assert property ($fell(ready) |-> ##[250:300] ready)
    else $error("busy length off");
endmodule
bind flash_read_core flash_read_sva chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
  .si(si), .so_out(so_out), .so_oe(so_oe), .ready(ready), .load_en(load_en),
  .load_addr(load_addr), .load_data(load_data));
`default_nettype wire

// ---- test/flash_host.sv ----
/* Host side model: mode 0 serial master.
   Assumes so_pin is the resolved output wire. */
`default_nettype none
module flash_host
(
  output var logic cs_n,
  output var logic sck,
  output var logic si,
  input wire logic so_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // frame
  // ********
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic frame(input logic [63:0] cmd, input int nb, input int nr,
    output logic [63:0] rd);
    rd = '0;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < nb + nr; i++)
    begin
      sck = 1'b0;
      si = (i < nb) ? cmd[63-i] : ~si;
      #100;
      sck = 1'b1;
      #95;
      if (i >= nb)
        rd = {rd[62:0], so_pin};
      #5;
    end
    sck = 1'b0;
    #100;
    cs_n = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

// ---- test/serial_flash_read_transfer_compare_test.sv ----
/* Bench for flash_read_core with a byte model.
   Assumes flash_host drives the serial pins. */
`default_nettype none
module serial_flash_read_transfer_compare_test;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_read_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load_en = 1'b0;
  logic [MEM_AW-1:0] load_addr = '0;
  logic [7:0] load_data = 8'h00;
  wire logic cs_n, sck, si, so_pin;
  logic so_out, so_oe, ready, cmp_m;
  int fails = 0, n_tests = 0, cycles = 0, pa, pb;
  logic [31:0] seed = 32'h8f26_f33e;
  logic [63:0] rd;
  logic [7:0] mem [int];
  logic [7:0] bufm [2][PAGE_BYTES];
  assign so_pin = so_oe ? so_out : 1'bz;
  flash_host host (.cs_n(cs_n), .sck(sck), .si(si), .so_pin(so_pin));
  flash_read_core dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_out), .so_oe(so_oe), .ready(ready), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data));
  // ********
  // helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [63:0] exp_bytes(int p, int ofs, int n, int b);
    logic [63:0] r = '0;
    for (int k = 0; k < n; k++)
      r = {r[55:0], (b < 0) ? mem[p*PAGE_BYTES+(ofs+k)%PAGE_BYTES] : bufm[b][(ofs+k)%PAGE_BYTES]};
    return r;
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic load_page(input int p, input int src);
    for (int k = 0; k < PAGE_BYTES; k++)
    begin
      @(negedge clk);
      seed = xs(seed);
      load_en = 1'b1;
      load_addr = MEM_AW'(p * PAGE_BYTES + k);
      load_data = (src < 0) ? seed[7:0] : mem[src*PAGE_BYTES+k] ^ 8'(k == PAGE_BYTES - 1);
      mem[p*PAGE_BYTES+k] = load_data;
    end
    @(negedge clk);
    load_en = 1'b0;
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 1000 && ready !== 1'b1; k++)
      @(posedge clk);
    @(negedge clk);
    check(ready, 64'h1);
  endtask
  task automatic status_is(input logic [7:0] e);
    host.frame({OP_STATUS, 56'h0}, 8, 16, rd);
    check(rd, {48'h0, e, e});
  endtask
  task automatic array_op(input logic [7:0] op, input int p);
    host.frame({op, 3'h0, 12'(p), 9'h0, 32'h0}, 32, 0, rd);
    check(ready, 64'h0);
  endtask
  // ********
  // run
  // ********
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    cmp_m = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    seed = xs(seed);
    pa = int'(seed[11:0]);
    pb = pa ^ 1;
    load_page(pa, -1);
    load_page(pb, pa);
    host.frame({OP_PAGE_READ, 3'h0, 12'(pa), 9'd260, 32'h0}, 64, 64, rd);
    check(rd, exp_bytes(pa, 260, 8, -1));
    $display("page read test done");
    for (int b = 0; b < 2; b++)
    begin
      array_op(OP_XFER_BUF1 + 8'(2 * b), pa);
      for (int k = 0; k < PAGE_BYTES; k++)
        bufm[b][k] = mem[pa*PAGE_BYTES+k];
      status_is({1'b0, cmp_m, 6'h0});
      wait_ready();
      host.frame({OP_BUF1_READ + 8'(2 * b), 15'h0, 9'd262, 32'h0}, 40, 32, rd);
      check(rd, exp_bytes(0, 262, 4, b));
      array_op(OP_CMP_BUF1 + 8'(b), pb);
      wait_ready();
      status_is(8'hc0);
      cmp_m = 1'b1;
      array_op(OP_CMP_BUF1 + 8'(b), pa);
      status_is({1'b0, cmp_m, 6'h0});
      cmp_m = 1'b0;
      wait_ready();
      status_is(8'h80);
      $display("buffer %0d test done", b + 1);
    end
    host.frame({OP_XFER_BUF2, 56'h0}, 16, 0, rd);
    check(ready, 64'h1);
    host.frame({OP_BUF2_READ, 15'h0, 9'h0, 32'h0}, 40, 32, rd);
    check(rd, exp_bytes(0, 0, 4, 1));
    $display("partial command test done");
    final_report();
  end
endmodule
`default_nettype wire
